// ---- shared/fcs_pkg.sv ----
// Package of constants and types for the flash command sequencer host
package fcs_pkg;
  // ********************
  // Register map
  // ********************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam int CTRL_START = 0;
  localparam int CTRL_OP_LO = 1;
  localparam int CTRL_VPP = 8;
  localparam int CTRL_IDV = 9;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ERR = 1;
  localparam int STAT_OK = 2;
  localparam int STAT_SUPPLY = 3;
  localparam int ADDR_W = 17;
  // ********************
  // Command bytes
  // ********************
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_ERASE_CHK = 8'hA0;
  localparam logic [7:0] CMD_PROG = 8'h40;
  localparam logic [7:0] CMD_PROG_CHK = 8'hC0;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [ADDR_W-1:0] LOC_MAKER = 17'h00000;
  localparam logic [ADDR_W-1:0] LOC_PART = 17'h00001;
  // ********************
  // Timing
  // ********************
  localparam int CLK_MHZ = 10;
  localparam int PROG_PULSE_US = 10;
  localparam int ERASE_PULSE_MS = 10;
  localparam int WE_PULSE_NS = 100;
  localparam int SETUP_NS = 100;
  localparam int HOLD_NS = 100;
  localparam int ACCESS_NS = 200;
  localparam int PROG_PULSE_CYC = PROG_PULSE_US * CLK_MHZ;
  localparam int ERASE_PULSE_CYC = ERASE_PULSE_MS * 1000 * CLK_MHZ;
  localparam int WE_PULSE_CYC = (WE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_CYC = 2;
  // ********************
  // Types
  // ********************
  typedef enum logic [2:0] {
    OP_CMD, OP_READ, OP_READ_ARRAY, OP_IDENT, OP_PROGRAM, OP_ERASE, OP_RESET
  } fcs_op_t;
  typedef enum logic [1:0] {K_WR, K_RD, K_WAIT, K_END} fcs_kind_t;
endpackage

// ---- shared/fcs_cyc_if.sv ----
// Interface carrying one flash bus cycle request between sequencer and engine
`timescale 1ns/1ps
interface fcs_cyc_if;
  logic req;
  logic wr;
  logic [16:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// ---- rtl/fcs_cycle_engine.sv ----
// Engine that runs one read or write cycle on the flash pins
`timescale 1ns/1ps
module fcs_cycle_engine import fcs_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  fcs_cyc_if.eng cyc,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [ADDR_W-1:0] addr,
  output logic [7:0] dq_out,
  output logic dq_oe_n,
  input wire logic [7:0] dq_in
);
  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_RECOVER} fcs_eng_t;
  fcs_eng_t state;
  logic [7:0] cnt;
  logic [7:0] dq_s1;
  logic [7:0] dq_s2;

  // ********************
  // Pin input synchroniser
  // ********************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
    end else begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
    end
  end

  // ********************
  // Cycle sequencing
  // ********************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= E_IDLE;
      cnt <= 8'h00;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      addr <= '0;
      dq_out <= 8'h00;
      dq_oe_n <= 1'b1;
      cyc.done <= 1'b0;
      cyc.rdata <= 8'h00;
    end else begin
      cyc.done <= 1'b0;
      case (state)
        E_IDLE: begin
          if (cyc.req && !cyc.done) begin
            ce_n <= 1'b0;
            addr <= cyc.addr;
            oe_n <= cyc.wr;
            dq_oe_n <= !cyc.wr;
            dq_out <= cyc.wdata;
            cnt <= cyc.wr ? 8'(SETUP_CYC) : 8'(ACCESS_CYC + SYNC_CYC);
            state <= E_SETUP;
          end
        end
        E_SETUP: begin
          if (cnt > 8'h01) begin
            cnt <= cnt - 8'h01;
          end else if (cyc.wr) begin
            we_n <= 1'b0;
            cnt <= 8'(WE_PULSE_CYC);
            state <= E_STROBE;
          end else begin
            // Data sampled after the two-stage synchroniser has settled
            cyc.rdata <= dq_s2;
            oe_n <= 1'b1;
            ce_n <= 1'b1;
            cyc.done <= 1'b1;
            state <= E_IDLE;
          end
        end
        E_STROBE: begin
          if (cnt > 8'h01) begin
            cnt <= cnt - 8'h01;
          end else begin
            we_n <= 1'b1;
            cnt <= 8'(HOLD_CYC);
            state <= E_RECOVER;
          end
        end
        E_RECOVER: begin
          if (cnt > 8'h01) begin
            cnt <= cnt - 8'h01;
          end else begin
            dq_oe_n <= 1'b1;
            ce_n <= 1'b1;
            cyc.done <= 1'b1;
            state <= E_IDLE;
          end
        end
        default: state <= E_IDLE;
      endcase
    end
  end
endmodule

// ---- rtl/fcs_host_ctrl.sv ----
// Host controller that drives a parallel flash through its command latch
`timescale 1ns/1ps
module fcs_host_ctrl import fcs_pkg::*; #(
  parameter int ERASE_CYC = ERASE_PULSE_CYC,
  parameter int PROG_CYC = PROG_PULSE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe_n,
  input wire logic [7:0] flash_dq_in,
  output logic program_supply_high,
  output logic identify_high_voltage,
  input wire logic supply_above_lockout
);
  typedef enum logic [1:0] {S_IDLE, S_STEP, S_BUS, S_HOLD} fcs_seq_t;

  logic rst_s1;
  logic rst_s2;
  logic rst;
  logic sup_s1;
  logic sup_ok;
  fcs_seq_t state;
  fcs_op_t op;
  logic [2:0] idx;
  logic [ADDR_W-1:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic rd_slot;
  logic vpp_en;
  logic idv_en;
  logic err;
  logic ok;
  logic [31:0] timer;
  logic wr_acc;
  logic rd_setup;
  logic hit;
  logic start;
  logic refuse;
  logic rd_done;
  fcs_kind_t kind;
  fcs_cyc_if cyc ();

  // ********************
  // Reset and pin synchronisers
  // ********************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  assign rst = !rst_s2;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sup_s1 <= 1'b0;
      sup_ok <= 1'b0;
    end else begin
      sup_s1 <= supply_above_lockout;
      sup_ok <= sup_s1;
    end
  end

  // ********************
  // Step tables
  // ********************
  function automatic fcs_kind_t step_kind(input fcs_op_t o, input logic [2:0] i);
    step_kind = K_END;
    case (o)
      OP_CMD: step_kind = (i == 3'd0) ? K_WR : K_END;
      OP_READ: step_kind = (i == 3'd0) ? K_RD : K_END;
      OP_READ_ARRAY: step_kind = (i == 3'd0) ? K_WR : (i == 3'd1) ? K_RD : K_END;
      OP_IDENT: step_kind = (i == 3'd0) ? K_WR : (i <= 3'd2) ? K_RD : K_END;
      OP_PROGRAM, OP_ERASE: begin
        case (i)
          3'd0, 3'd1, 3'd3: step_kind = K_WR;
          3'd2: step_kind = K_WAIT;
          3'd4: step_kind = K_RD;
          default: step_kind = K_END;
        endcase
      end
      OP_RESET: step_kind = (i <= 3'd1) ? K_WR : K_END;
      default: step_kind = K_END;
    endcase
  endfunction

  function automatic logic [7:0] step_byte(input fcs_op_t o, input logic [2:0] i,
                                           input logic [7:0] d);
    step_byte = CMD_READ;
    case (o)
      OP_CMD: step_byte = d;
      OP_IDENT: step_byte = CMD_IDENT;
      OP_PROGRAM: step_byte = (i == 3'd0) ? CMD_PROG : (i == 3'd1) ? d : CMD_PROG_CHK;
      OP_ERASE: step_byte = (i == 3'd3) ? CMD_ERASE_CHK : CMD_ERASE;
      OP_RESET: step_byte = CMD_RESET;
      default: step_byte = CMD_READ;
    endcase
  endfunction

  function automatic logic [ADDR_W-1:0] step_addr(input fcs_op_t o, input logic [2:0] i,
                                                  input logic [ADDR_W-1:0] a);
    step_addr = '0;
    case (o)
      OP_CMD, OP_READ, OP_READ_ARRAY: step_addr = a;
      OP_IDENT: step_addr = (i == 3'd2) ? LOC_PART : LOC_MAKER;
      OP_PROGRAM: step_addr = (i == 3'd1 || i == 3'd4) ? a : '0;
      OP_ERASE: step_addr = (i >= 3'd3) ? a : '0;
      default: step_addr = '0;
    endcase
  endfunction

  assign kind = step_kind(op, idx);

  // ********************
  // APB slave
  // ********************
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign hit = (paddr == REG_CTRL) || (paddr == REG_ADDR) || (paddr == REG_WDATA) ||
               (paddr == REG_STATUS) || (paddr == REG_RDATA);
  assign pslverr = psel && penable && !hit;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      case (paddr)
        REG_CTRL: prdata <= {22'h000000, idv_en, vpp_en, 4'h0, op, 1'b0};
        REG_ADDR: prdata <= {15'h0000, addr_reg};
        REG_WDATA: prdata <= {24'h000000, wdata_reg};
        REG_STATUS: prdata <= {28'h0000000, sup_ok, ok, err, state != S_IDLE};
        REG_RDATA: prdata <= {16'h0000, rdata_reg};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_reg <= '0;
      wdata_reg <= 8'h00;
      vpp_en <= 1'b0;
      idv_en <= 1'b0;
    end else if (wr_acc && state == S_IDLE) begin
      // Settings frozen while a sequence runs so it sees one consistent set
      if (paddr == REG_ADDR) begin
        addr_reg <= pwdata[ADDR_W-1:0];
      end
      if (paddr == REG_WDATA) begin
        wdata_reg <= pwdata[7:0];
      end
      if (paddr == REG_CTRL) begin
        vpp_en <= pwdata[CTRL_VPP];
        idv_en <= pwdata[CTRL_IDV];
      end
    end
  end

  assign program_supply_high = vpp_en;
  assign identify_high_voltage = idv_en;

  // ********************
  // Sequencer
  // ********************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      op <= OP_READ;
      idx <= 3'd0;
      timer <= 32'h00000000;
      cyc.req <= 1'b0;
      cyc.wr <= 1'b0;
      cyc.addr <= '0;
      cyc.wdata <= 8'h00;
    end else begin
      case (state)
        S_IDLE: begin
          if (start) begin
            op <= fcs_op_t'(pwdata[CTRL_OP_LO+2:CTRL_OP_LO]);
            idx <= 3'd0;
            state <= S_STEP;
          end
        end
        S_STEP: begin
          case (kind)
            K_WR: begin
              if (refuse) begin
                state <= S_IDLE;
              end else begin
                cyc.req <= 1'b1;
                cyc.wr <= 1'b1;
                cyc.addr <= step_addr(op, idx, addr_reg);
                cyc.wdata <= step_byte(op, idx, wdata_reg);
                state <= S_BUS;
              end
            end
            K_RD: begin
              cyc.req <= 1'b1;
              cyc.wr <= 1'b0;
              cyc.addr <= step_addr(op, idx, addr_reg);
              state <= S_BUS;
            end
            K_WAIT: begin
              // Pulse length is a floor; the verify write that follows ends it
              timer <= (op == OP_ERASE) ? 32'(ERASE_CYC) : 32'(PROG_CYC);
              state <= S_HOLD;
            end
            default: state <= S_IDLE;
          endcase
        end
        S_BUS: begin
          if (cyc.done) begin
            cyc.req <= 1'b0;
            idx <= idx + 3'd1;
            state <= S_STEP;
          end
        end
        S_HOLD: begin
          if (timer > 32'h00000001) begin
            timer <= timer - 32'h00000001;
          end else begin
            idx <= idx + 3'd1;
            state <= S_STEP;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ********************
  // Status flags and read capture
  // ********************
  assign start = (state == S_IDLE) && wr_acc && (paddr == REG_CTRL) && pwdata[CTRL_START];
  // Checked on every write step, so a supply dip mid-sequence stops it
  assign refuse = (state == S_STEP) && (kind == K_WR) && (!vpp_en || !sup_ok);
  assign rd_done = (state == S_BUS) && cyc.done && !cyc.wr;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      err <= 1'b0;
    end else if (start) begin
      err <= 1'b0;
    end else if (refuse) begin
      err <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_slot <= 1'b0;
      rdata_reg <= 16'h0000;
      ok <= 1'b0;
    end else if (start) begin
      rd_slot <= 1'b0;
      ok <= 1'b0;
    end else if (rd_done) begin
      // Second read of a pair lands in the upper byte
      rd_slot <= 1'b1;
      if (rd_slot) begin
        rdata_reg[15:8] <= cyc.rdata;
      end else begin
        rdata_reg <= {8'h00, cyc.rdata};
      end
      if (op == OP_PROGRAM) begin
        ok <= (cyc.rdata == wdata_reg);
      end else if (op == OP_ERASE) begin
        ok <= (cyc.rdata == ERASED_BYTE);
      end
    end
  end

  // ********************
  // Pin engine
  // ********************
  fcs_cycle_engine u_engine (
    .clk_sys(clk_sys),
    .rst(rst),
    .cyc(cyc.eng),
    .ce_n(flash_ce_n),
    .oe_n(flash_oe_n),
    .we_n(flash_we_n),
    .addr(flash_addr),
    .dq_out(flash_dq_out),
    .dq_oe_n(flash_dq_oe_n),
    .dq_in(flash_dq_in)
  );
endmodule

// ---- bench/fcs_host_ctrl_chk.sv ----
// Checker of the host controller port behaviour
`timescale 1ns/1ps
module fcs_host_ctrl_chk import fcs_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_dq_oe_n,
  input wire logic program_supply_high,
  input wire logic supply_above_lockout
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic unmapped;
  assign unmapped = !(paddr inside {REG_CTRL, REG_ADDR, REG_WDATA, REG_STATUS, REG_RDATA});
  sequence wr_cyc;
    (!flash_ce_n) [*3] ##1 flash_ce_n;
  endsequence
  sequence rd_cyc;
    (!flash_ce_n && !flash_oe_n) [*4] ##1 (flash_ce_n && flash_oe_n);
  endsequence
  chk_apb_ready: assert property (psel |-> pready) else $error("pready low");
  chk_slverr_map: assert property (psel && penable |-> pslverr == unmapped)
    else $error("pslverr wrong");
  chk_we_selected: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
    else $error("strobe outside write cycle");
  chk_we_pulse: assert property ($fell(flash_we_n) |=> flash_we_n)
    else $error("strobe not one cycle");
  chk_we_supply: assert property ($fell(flash_we_n) |-> program_supply_high)
    else $error("write without supply");
  chk_we_lockout: assert property ($fell(flash_we_n) |-> supply_above_lockout)
    else $error("write under lockout");
  chk_no_contend: assert property (!flash_oe_n |-> flash_dq_oe_n)
    else $error("host drives during read");
  chk_write_len: assert property ($fell(flash_ce_n) && flash_oe_n |-> wr_cyc)
    else $error("write cycle length");
  chk_read_len: assert property ($fell(flash_ce_n) && !flash_oe_n |-> rd_cyc)
    else $error("read cycle length");
  chk_ce_gap: assert property ($rose(flash_ce_n) |-> flash_ce_n [*2])
    else $error("select gap short");
endmodule
bind fcs_host_ctrl fcs_host_ctrl_chk u_chk (.clk_sys, .rst_n, .psel, .penable, .paddr,
  .pready, .pslverr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_oe_n,
  .program_supply_high, .supply_above_lockout);

// ---- bench/fcs_flash_model.sv ----
// Behavioural model of the byte-wide flash with its command latch
`timescale 1ns/1ps
module fcs_flash_model import fcs_pkg::*; #(
  parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value
  parameter logic [7:0] PART_CODE = 8'hD2, // Arbitrary value
  parameter int MIN_PULSE_NS = 1000, // Floor scaled to the bench's short waits
  parameter int STOP_NS = 100000
) (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [16:0] addr,
  input wire logic [7:0] din,
  input wire logic vpp,
  input wire logic id_hv,
  input wire logic vcc_ok,
  output logic [7:0] dout
);
  // Only 256 bytes kept to stay small
  logic [7:0] mem [0:255];
  logic [7:0] cmd = 8'h00;
  logic [16:0] wa = 17'h0;
  logic [16:0] ea = 17'h0;
  logic [16:0] pa = 17'h0;
  logic [1:0] setup = 2'd0;
  logic ff_seen = 1'b0;
  logic [7:0] rd;
  logic [7:0] idle_q = 8'hA5;
  realtime pulse_t0 = 0.0;
  logic pulse_on = 1'b0;
  logic pulse_short = 1'b0;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  always @(negedge we_n) if (!ce_n) wa = addr;
  always @(negedge vpp) begin
    cmd = 8'h00;
    setup = 2'd0;
  end
  // Pulses act at once, then idle until verify
  always @(posedge we_n) begin
    if (!ce_n && vpp && vcc_ok) begin
      if (setup == 2'd2 && din != CMD_RESET) begin
        mem[wa[7:0]] = din;
        pa = wa;
        setup = 2'd0;
        cmd = CMD_PROG;
        pulse_t0 = $realtime;
        pulse_on = 1'b1;
      end else if (setup == 2'd1 && din == CMD_ERASE) begin
        for (int i = 0; i < 256; i++) mem[i] = ERASED_BYTE;
        setup = 2'd0;
        cmd = CMD_ERASE;
        pulse_t0 = $realtime;
        pulse_on = 1'b1;
      end else if (din == CMD_RESET) begin
        if (ff_seen) setup = 2'd0;
      end else begin
        if ((din == CMD_ERASE_CHK || din == CMD_PROG_CHK) && pulse_on) begin
          if ($realtime - pulse_t0 < MIN_PULSE_NS) pulse_short = 1'b1;
          pulse_on = 1'b0;
        end
        case (din)
          CMD_ERASE: setup = 2'd1;
          CMD_PROG: setup = 2'd2;
          CMD_ERASE_CHK: begin
            ea = wa;
            cmd = din;
          end
          CMD_READ, CMD_IDENT, CMD_PROG_CHK: cmd = din;
          default: ;
        endcase
      end
      ff_seen = (din == CMD_RESET) && !ff_seen;
    end
  end
  // Stop timer closes a pulse that no verify ever ends
  always @(posedge pulse_on) begin
    #(STOP_NS);
    pulse_on = 1'b0;
  end
  always_comb begin
    rd = mem[addr[7:0]];
    if (id_hv) rd = addr[0] ? PART_CODE : MAKER_CODE;
    else if (vpp && cmd == CMD_IDENT) rd = addr[0] ? PART_CODE : MAKER_CODE;
    else if (vpp && cmd == CMD_ERASE_CHK) rd = mem[ea[7:0]];
    else if (vpp && cmd == CMD_PROG_CHK) rd = mem[pa[7:0]];
  end
  // Released bus shows no stale value
  always @(posedge oe_n or posedge ce_n) idle_q <= ~rd;
  assign dout = (!ce_n && !oe_n) ? rd : idle_q;
endmodule

// ---- bench/testbench.sv ----
// Self-checking testbench of the flash host controller
`timescale 1ns/1ps
module testbench import fcs_pkg::*;;
  localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value
  localparam logic [7:0] PART = 8'hD2; // Arbitrary value
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic supply_ok = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, ce_n, oe_n, we_n, dq_oe_n, vpp, id_hv;
  logic [16:0] faddr;
  logic [7:0] dq_o, dq_i;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  always #50 clk_sys = ~clk_sys;
  fcs_host_ctrl #(.ERASE_CYC(20), .PROG_CYC(5)) u_fcs_host_ctrl (.clk_sys(clk_sys),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(faddr),
    .flash_dq_out(dq_o), .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_i),
    .program_supply_high(vpp), .identify_high_voltage(id_hv),
    .supply_above_lockout(supply_ok));
  fcs_flash_model u_fcs_flash_model (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(faddr),
    .din(dq_o), .vpp(vpp), .id_hv(id_hv), .vcc_ok(supply_ok), .dout(dq_i));
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Runs one operation, returns status and the read word
  task run(input logic [2:0] op, input logic [16:0] a, input logic [7:0] wd,
           input logic v, input logic idv, output logic [31:0] st, output logic [31:0] q);
    apb(1'b1, REG_ADDR, {15'h0, a}, q);
    apb(1'b1, REG_WDATA, {24'h0, wd}, q);
    apb(1'b1, REG_CTRL, {22'h0, idv, v, 4'h0, op, 1'b1}, q);
    do apb(1'b0, REG_STATUS, 32'h0, st); while (st[STAT_BUSY] !== 1'b0);
    apb(1'b0, REG_RDATA, 32'h0, q);
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      end_of_test;
    end
  end
  initial begin
    logic [31:0] st, q;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    apb(1'b0, 8'h14, 32'h0, q);
    check("unmapped read", q, 32'h0);
    run(3'd3, 17'h0, 8'h00, 1'b1, 1'b0, st, q);
    check("ident codes", q[15:0], {PART, MAKER});
    apb(1'b1, REG_CTRL, 32'h0, q);
    run(3'd1, 17'h0, 8'h00, 1'b0, 1'b0, st, q);
    check("supply low read", q[7:0], 8'h5A);
    run(3'd1, 17'h1, 8'h00, 1'b0, 1'b1, st, q);
    check("raised bit nine", q[7:0], PART);
    apb(1'b0, REG_CTRL, 32'h0, q);
    check("control readback", q, 32'h00000202);
    $display("identify tests finished");
    run(3'd2, 17'h5, 8'h00, 1'b1, 1'b0, st, q);
    check("array read", q[7:0], 8'h5F);
    run(3'd0, 17'h0, 8'h33, 1'b1, 1'b0, st, q);
    run(3'd1, 17'h5, 8'h00, 1'b1, 1'b0, st, q);
    check("undefined ignored", q[7:0], 8'h5F);
    run(3'd0, 17'h0, CMD_PROG, 1'b1, 1'b0, st, q);
    run(3'd6, 17'h0, 8'h00, 1'b1, 1'b0, st, q);
    run(3'd2, 17'h0, 8'h00, 1'b1, 1'b0, st, q);
    check("abort keeps data", q[7:0], 8'h5A);
    $display("read tests finished");
    run(3'd4, 17'h7, 8'h12, 1'b1, 1'b0, st, q);
    check("program ok", st[STAT_OK], 1'b1);
    run(3'd2, 17'h7, 8'h00, 1'b1, 1'b0, st, q);
    check("programmed byte", q[7:0], 8'h12);
    run(3'd4, 17'h8, 8'h34, 1'b0, 1'b0, st, q);
    check("no supply refused", st[STAT_ERR], 1'b1);
    supply_ok <= 1'b0;
    repeat (4) @(posedge clk_sys);
    run(3'd4, 17'h8, 8'h34, 1'b1, 1'b0, st, q);
    check("lockout refused", st[STAT_ERR], 1'b1);
    check("supply flag", st[STAT_SUPPLY], 1'b0);
    supply_ok <= 1'b1;
    repeat (4) @(posedge clk_sys);
    run(3'd2, 17'h8, 8'h00, 1'b1, 1'b0, st, q);
    check("byte unchanged", q[7:0], 8'h52);
    $display("program tests finished");
    run(3'd5, 17'h9, 8'h00, 1'b1, 1'b0, st, q);
    check("erase ok", st[STAT_OK], 1'b1);
    check("pulse floor", u_fcs_flash_model.pulse_short, 1'b0);
    run(3'd2, 17'h7, 8'h00, 1'b1, 1'b0, st, q);
    check("erased byte", q[7:0], ERASED_BYTE);
    $display("erase tests finished");
    end_of_test;
  end
endmodule
